//--- include/ledind_pkg.sv
// package for the led indicator logic: register map, colour codes, field layout
// assumes a 32-bit axi4-lite register bus and one 200 MHz clock
package ledind_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_LEDS   = 8;
  localparam int unsigned NUM_INPUTS = 5;
  localparam int unsigned SIG_W      = 32;   // status signals offered for assignment
  localparam int unsigned SEL_W      = 5;    // index into the status signal list

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned BLINK_HALF_MS = 250;   // half period of the flash pattern
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

  // ---------------------------------------------------------------
  // colour setting encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LEDIND_OFF         = 3'h0,
    LEDIND_GREEN       = 3'h1,
    LEDIND_RED         = 3'h2,
    LEDIND_RED_FLASH   = 3'h3,
    LEDIND_GREEN_FLASH = 3'h4
  } ledind_colour_t;

  // per-led configuration word layout
  localparam int unsigned F_LATCH    = 0;
  localparam int unsigned F_ACT_LSB  = 4;
  localparam int unsigned F_INACT_LSB = 8;
  localparam int unsigned F_INV_LSB  = 12;
  localparam int unsigned F_ACK_LSB  = 24;
  localparam int unsigned COL_W      = 3;

  // per-led assignment word layout: five 5-bit selectors plus enables
  localparam int unsigned F_EN_LSB   = 25;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG_BASE = 8'h00;  // 8 words, one per led
  localparam logic [7:0] ADDR_ASG_BASE = 8'h20;  // 8 words, one per led
  localparam logic [7:0] ADDR_STATE    = 8'h40;  // read only led state
  localparam logic [7:0] ADDR_SIGS     = 8'h44;  // read only status inputs
  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
  localparam logic [31:0] ASG_RESET    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // one led's settings as carried to the per-led cell
  typedef struct packed {
    logic [NUM_INPUTS-1:0]            en;
    logic [NUM_INPUTS-1:0][SEL_W-1:0] sel;
    logic [NUM_INPUTS-1:0]            inv;
    logic                             latch;
    logic [SEL_W-1:0]                 ack_sel;
    ledind_colour_t                   act_col;
    ledind_colour_t                   inact_col;
  } ledind_cfg_t;

  typedef struct packed {
    logic red;
    logic green;
  } ledind_drive_t;

endpackage

//--- hdl/ledind_cell.sv
// one led: inversion, or function, latch with acknowledge, colour pick
// assumes status signals synchronous to aclk and a shared blink phase
`timescale 1ns/10ps
`default_nettype none

module ledind_cell (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire ledind_pkg::ledind_cfg_t           cfg,
  input  wire logic [ledind_pkg::SIG_W-1:0]      sigs,
  input  wire logic                              blink,
  output var  ledind_pkg::ledind_drive_t         drive,
  output logic                                   state
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic ledind_pkg::ledind_drive_t colour_drive(
    input ledind_pkg::ledind_colour_t c, input logic ph);
    ledind_pkg::ledind_drive_t d;
    d = '0;
    case (c)
      ledind_pkg::LEDIND_GREEN:       d.green = 1'b1;
      ledind_pkg::LEDIND_RED:         d.red   = 1'b1;
      ledind_pkg::LEDIND_RED_FLASH:   d.red   = ph;
      ledind_pkg::LEDIND_GREEN_FLASH: d.green = ph;
      default:                        d       = '0;
    endcase
    return d;
  endfunction

  logic                     or_now;
  logic                     held_ff;
  logic                     nxt_held;
  ledind_pkg::ledind_drive_t drive_ff;
  ledind_pkg::ledind_drive_t nxt_drive;

  // ---------------------------------------------------------------
  // or function over the assigned inputs
  // ---------------------------------------------------------------
  always_comb begin
    or_now = 1'b0;
    for (int i = 0; i < ledind_pkg::NUM_INPUTS; i++) begin
      if (cfg.en[i]) begin
        or_now = or_now | (sigs[cfg.sel[i]] ^ cfg.inv[i]);
      end
    end
  end

  // ---------------------------------------------------------------
  // latch and output colour
  // ---------------------------------------------------------------
  // ack only counts once the cause has gone, so a held-down ack cannot
  // mask a fault that is still present
  always_comb begin
    nxt_held = held_ff;
    if (!cfg.latch) begin
      nxt_held = 1'b0;
    end else if (or_now) begin
      nxt_held = 1'b1;
    end else if (sigs[cfg.ack_sel]) begin
      nxt_held = 1'b0;
    end
    if (or_now || (cfg.latch && held_ff)) begin
      nxt_drive = colour_drive(cfg.act_col, blink);
    end else begin
      nxt_drive = colour_drive(cfg.inact_col, blink);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_ff  <= 1'b0;
      drive_ff <= '0;
    end else begin
      held_ff  <= nxt_held;
      drive_ff <= nxt_drive;
    end
  end

  assign drive = drive_ff;
  assign state = or_now | held_ff;

endmodule // ledind_cell

`default_nettype wire

//--- hdl/ledind_top.sv
// led indicator logic: axi4-lite register file, blink divider, led cells
// assumes status signals synchronous to aclk; led drivers take red/green levels
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - true or result shows active colour
// - false or result shows inactive colour
// - each input has own inversion option
// - latch keeps active indication until acknowledged
// - acknowledge clears only once cause gone
// - acknowledge selection unused without latch
// - colours: green, red, flashes, off
module ledind_top #(
  parameter int unsigned BLINK_HALF = ledind_pkg::BLINK_HALF_CYC
) (
  input  wire logic                                    aclk,
  input  wire logic                                    aresetn,
  input  wire logic [7:0]                              s_axi_awaddr,
  input  wire logic                                    s_axi_awvalid,
  output logic                                         s_axi_awready,
  input  wire logic [31:0]                             s_axi_wdata,
  input  wire logic [3:0]                              s_axi_wstrb,
  input  wire logic                                    s_axi_wvalid,
  output logic                                         s_axi_wready,
  output logic [1:0]                                   s_axi_bresp,
  output logic                                         s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  input  wire logic [7:0]                              s_axi_araddr,
  input  wire logic                                    s_axi_arvalid,
  output logic                                         s_axi_arready,
  output logic [31:0]                                  s_axi_rdata,
  output logic [1:0]                                   s_axi_rresp,
  output logic                                         s_axi_rvalid,
  input  wire logic                                    s_axi_rready,
  input  wire logic [ledind_pkg::SIG_W-1:0]            status_sigs,
  output var  ledind_pkg::ledind_drive_t [ledind_pkg::NUM_LEDS-1:0] led_drive
);

  localparam int unsigned N = ledind_pkg::NUM_LEDS;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [N-1:0][31:0] cfg_ff,   nxt_cfg;
  logic [N-1:0][31:0] asg_ff,   nxt_asg;
  logic [31:0]        bcnt_ff,  nxt_bcnt;
  logic               blink_ff, nxt_blink;
  logic               aw_ff,    nxt_aw;
  logic               w_ff,     nxt_w;
  logic [7:0]         awa_ff,   nxt_awa;
  logic [31:0]        wd_ff,    nxt_wd;
  logic [3:0]         ws_ff,    nxt_ws;
  logic               bv_ff,    nxt_bv;
  logic [1:0]         br_ff,    nxt_br;
  logic               rv_ff,    nxt_rv;
  logic [31:0]        rd_ff,    nxt_rd;
  logic [1:0]         rr_ff,    nxt_rr;
  logic [N-1:0]       led_state;
  ledind_pkg::ledind_cfg_t [N-1:0] cell_cfg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction

  // unmapped or unaligned addresses answer slverr
  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ledind_pkg::ADDR_SIGS);
  endfunction

  // ---------------------------------------------------------------
  // blink divider
  // ---------------------------------------------------------------
  // one shared phase keeps all flashing leds in step
  always_comb begin
    nxt_bcnt  = bcnt_ff + 32'h1;
    nxt_blink = blink_ff;
    if (bcnt_ff >= 32'(BLINK_HALF - 1)) begin
      nxt_bcnt  = 32'h0;
      nxt_blink = ~blink_ff;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  // address and data are captured independently, write fires once both held
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_asg = asg_ff;
    nxt_aw  = aw_ff;
    nxt_w   = w_ff;
    nxt_awa = awa_ff;
    nxt_wd  = wd_ff;
    nxt_ws  = ws_ff;
    nxt_bv  = bv_ff;
    nxt_br  = br_ff;
    nxt_rv  = rv_ff;
    nxt_rd  = rd_ff;
    nxt_rr  = rr_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw  = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w  = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    if (aw_ff && w_ff && !bv_ff) begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = addr_ok(awa_ff) ? ledind_pkg::RESP_OKAY : ledind_pkg::RESP_SLVERR;
      if (awa_ff[1:0] == 2'h0 && awa_ff < ledind_pkg::ADDR_ASG_BASE) begin
        nxt_cfg[awa_ff[4:2]] = merge(cfg_ff[awa_ff[4:2]], wd_ff, ws_ff);
      end else if (awa_ff[1:0] == 2'h0 && awa_ff < ledind_pkg::ADDR_STATE) begin
        nxt_asg[awa_ff[4:2]] = merge(asg_ff[awa_ff[4:2]], wd_ff, ws_ff);
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rv = 1'b1;
      nxt_rr = addr_ok(s_axi_araddr) ? ledind_pkg::RESP_OKAY : ledind_pkg::RESP_SLVERR;
      nxt_rd = 32'h0;
      if (!addr_ok(s_axi_araddr)) begin
        nxt_rd = 32'h0;
      end else if (s_axi_araddr < ledind_pkg::ADDR_ASG_BASE) begin
        nxt_rd = cfg_ff[s_axi_araddr[4:2]];
      end else if (s_axi_araddr < ledind_pkg::ADDR_STATE) begin
        nxt_rd = asg_ff[s_axi_araddr[4:2]];
      end else if (s_axi_araddr == ledind_pkg::ADDR_STATE) begin
        nxt_rd = {24'h0, led_state};
      end else begin
        nxt_rd = status_sigs;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff   <= {N{ledind_pkg::CFG_RESET}};
      asg_ff   <= {N{ledind_pkg::ASG_RESET}};
      bcnt_ff  <= 32'h0;
      blink_ff <= 1'b0;
      aw_ff    <= 1'b0;
      w_ff     <= 1'b0;
      awa_ff   <= 8'h0;
      wd_ff    <= 32'h0;
      ws_ff    <= 4'h0;
      bv_ff    <= 1'b0;
      br_ff    <= 2'h0;
      rv_ff    <= 1'b0;
      rd_ff    <= 32'h0;
      rr_ff    <= 2'h0;
    end else begin
      cfg_ff   <= nxt_cfg;
      asg_ff   <= nxt_asg;
      bcnt_ff  <= nxt_bcnt;
      blink_ff <= nxt_blink;
      aw_ff    <= nxt_aw;
      w_ff     <= nxt_w;
      awa_ff   <= nxt_awa;
      wd_ff    <= nxt_wd;
      ws_ff    <= nxt_ws;
      bv_ff    <= nxt_bv;
      br_ff    <= nxt_br;
      rv_ff    <= nxt_rv;
      rd_ff    <= nxt_rd;
      rr_ff    <= nxt_rr;
    end
  end

  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready  = !w_ff && !bv_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;

  // ---------------------------------------------------------------
  // led cells
  // ---------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_led
    always_comb begin
      cell_cfg[g].latch     = cfg_ff[g][ledind_pkg::F_LATCH];
      cell_cfg[g].act_col   = ledind_pkg::ledind_colour_t'(
                                cfg_ff[g][ledind_pkg::F_ACT_LSB +: ledind_pkg::COL_W]);
      cell_cfg[g].inact_col = ledind_pkg::ledind_colour_t'(
                                cfg_ff[g][ledind_pkg::F_INACT_LSB +: ledind_pkg::COL_W]);
      cell_cfg[g].inv       = cfg_ff[g][ledind_pkg::F_INV_LSB +: ledind_pkg::NUM_INPUTS];
      cell_cfg[g].ack_sel   = cfg_ff[g][ledind_pkg::F_ACK_LSB +: ledind_pkg::SEL_W];
      cell_cfg[g].en        = asg_ff[g][ledind_pkg::F_EN_LSB +: ledind_pkg::NUM_INPUTS];
      for (int i = 0; i < ledind_pkg::NUM_INPUTS; i++) begin
        cell_cfg[g].sel[i]  = asg_ff[g][i*ledind_pkg::SEL_W +: ledind_pkg::SEL_W];
      end
    end

    ledind_cell u_cell (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cfg     (cell_cfg[g]),
      .sigs    (status_sigs),
      .blink   (blink_ff),
      .drive   (led_drive[g]),
      .state   (led_state[g])
    );
  end

endmodule // ledind_top

`default_nettype wire

//--- verification/ledind_sig_src.sv
// model of the protection functions that raise the assignable status flags
// assumes the bench tells it which flags to raise; flags follow on the next clock edge
`timescale 1ns/10ps
`default_nettype none

module ledind_sig_src (
  input  wire logic        aclk,
  input  wire logic [31:0] want,
  output logic      [31:0] status_sigs
);
  // -------------------------------------------------------------
  // flag register
  // -------------------------------------------------------------
  logic [31:0] nxt_flags;

  // flags change only on the clock, as a real protection function would
  always_comb begin
    nxt_flags = want;
  end

  always_ff @(posedge aclk) begin
    status_sigs <= nxt_flags;
  end
endmodule // ledind_sig_src

`default_nettype wire

//--- verification/ledind_top_monitor.sv
// checker for the led indicator top: bus handshake timing and led drive shape
// assumes it is bound to ledind_top and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none

module ledind_top_monitor #(
  parameter int unsigned BLINK_HALF = ledind_pkg::BLINK_HALF_CYC
) (
  input wire logic                                           aclk,
  input wire logic                                           aresetn,
  input wire logic                                           s_axi_awvalid,
  input wire logic                                           s_axi_awready,
  input wire logic                                           s_axi_wvalid,
  input wire logic                                           s_axi_wready,
  input wire logic                                           s_axi_bvalid,
  input wire logic                                           s_axi_bready,
  input wire logic                                           s_axi_arvalid,
  input wire logic                                           s_axi_arready,
  input wire logic                                           s_axi_rvalid,
  input wire logic                                           s_axi_rready,
  input wire ledind_pkg::ledind_drive_t [ledind_pkg::NUM_LEDS-1:0] led_drive
);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // flat copy so the two colour bits of every led can be masked at once
  logic [2*ledind_pkg::NUM_LEDS-1:0] ld;
  assign ld = led_drive;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_dark;
    $rose(aresetn) |-> ld == '0;
  endproperty
  a_reset_dark: assert property (p_reset_dark) else $error("led drive lit after reset");

  property p_one_colour;
    (ld & (ld >> 1) & {ledind_pkg::NUM_LEDS{2'b01}}) == '0;
  endproperty
  a_one_colour: assert property (p_one_colour) else $error("led lit red and green at once");

  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");

  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");

  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read address taken while data pending");

  property p_aw_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while response pending");

  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response repeated");

  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read data repeated");

  // main traffic and a red led 1 seen at least once
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_red: cover property (led_drive[1].red);
endmodule // ledind_top_monitor

bind ledind_top ledind_top_monitor #(.BLINK_HALF(BLINK_HALF)) ledind_top_monitor_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .led_drive
);

`default_nettype wire

//--- verification/test_ledind_top.sv
// self-checking bench for the led indicator logic over its register bus
// assumes a blink half period of 4 cycles so one flash period spans 8 cycles
`timescale 1ns/10ps
`default_nettype none

module test_ledind_top;
  localparam int unsigned HALF = 4;
  localparam logic [1:0]  OK   = ledind_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR  = ledind_pkg::RESP_SLVERR;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, want = 32'h0, s_axi_rdata, status_sigs;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  ledind_pkg::ledind_drive_t [ledind_pkg::NUM_LEDS-1:0] led_drive;
  int          num_errors = 0, num_checks = 0;

  always #2.5 aclk = ~aclk;

  ledind_sig_src ledind_sig_src_inst (.aclk, .want, .status_sigs);
  ledind_top #(.BLINK_HALF(HALF)) ledind_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .status_sigs, .led_drive
  );

  // -------------------------------------------------------------
  // report
  // -------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // -------------------------------------------------------------
  // bus master
  // -------------------------------------------------------------
  // handshakes are judged at the falling edge; ready is steady until the next rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic pa, pw, pb, ta, tw, tb;
    int   n;
    pa = 1'b1;
    pw = w;
    pb = 1'b1;
    q = 32'h0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 40 && (pa || pw || pb); n++) begin
      @(negedge aclk);
      ta = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      if (tb) begin
        q = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
      end
      @(posedge aclk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
      if (tb) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        pb = 1'b0;
      end
    end
    // judge by what is still open, so a handshake that ends on the last pass is not a timeout
    if (pa || pw || pb) begin
      num_errors++;
      $display("mismatch bus handshake expected done seen timeout");
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, d, q, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 32'h0, q, r);
    chk("rdata", e, q);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // -------------------------------------------------------------
  // status flags and led observation
  // -------------------------------------------------------------
  // three edges: flag source, latch release on acknowledge, led register
  task automatic put(input logic [31:0] v);
    @(posedge aclk);
    want <= v;
    repeat (3) @(posedge aclk);
  endtask

  // eight cycles cover one whole flash period, so a flash shows exactly four lit cycles
  task automatic look(input int g, input logic [2:0] c);
    logic [7:0] nr, ng, er, eg;
    nr = 8'h0;
    ng = 8'h0;
    repeat (8) begin
      @(negedge aclk);
      nr += led_drive[g].red;
      ng += led_drive[g].green;
    end
    er = (c == ledind_pkg::LEDIND_RED) ? 8'h8 : (c == ledind_pkg::LEDIND_RED_FLASH) ? 8'h4 : 8'h0;
    eg = (c == ledind_pkg::LEDIND_GREEN) ? 8'h8 : (c == ledind_pkg::LEDIND_GREEN_FLASH) ? 8'h4 : 8'h0;
    chk("led lit cycles", {16'h0, er, eg}, {16'h0, nr, ng});
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, ledind_pkg::CFG_RESET, OK);
    rd(8'h20, ledind_pkg::ASG_RESET, OK);
    look(0, 3'h0);
    // every code as active and as inactive colour, led 0 on flag 3
    wr(8'h20, 32'h0200_0003, OK);
    for (int c = 0; c < 5; c++) begin
      wr(8'h00, (c << 4) | (((c + 2) % 5) << 8), OK);
      put(32'h8);
      look(0, 3'(c));
      put(32'h0);
      look(0, 3'((c + 2) % 5));
    end
    // input 1 inverted on flag 3, input 5 on flag 7; green when true, red when false
    wr(8'h20, 32'h2270_0003, OK);
    wr(8'h00, 32'h0000_1210, OK);
    put(32'h0);
    look(0, 3'h1);
    put(32'h8);
    look(0, 3'h2);
    put(32'h88);
    look(0, 3'h1);
    // led 1 latched on flag 4, acknowledged by flag 9
    wr(8'h24, 32'h0200_0004, OK);
    wr(8'h04, 32'h0900_0121, OK);
    put(32'h10);
    look(1, 3'h2);
    put(32'h0);
    look(1, 3'h2);
    rd(8'h40, 32'h3, OK);
    put(32'h210);
    look(1, 3'h2);
    put(32'h0);
    look(1, 3'h2);
    put(32'h200);
    look(1, 3'h1);
    // latch off: acknowledge flag has no say
    wr(8'h04, 32'h0900_0120, OK);
    put(32'h210);
    look(1, 3'h2);
    put(32'h0);
    look(1, 3'h1);
    // refused and read-only places
    put(32'h210);
    rd(8'h44, 32'h210, OK);
    rd(8'h48, 32'h0, ERR);
    wr(8'h02, 32'hffff_ffff, ERR);
    wr(8'h44, 32'h1, OK);
    rd(8'h44, 32'h210, OK);
    rd(8'h00, 32'h0000_1210, OK);
    summarize();
  end
endmodule // test_ledind_top

`default_nettype wire
